// file: logic/mpd_defs.svh
// Register map, field positions, reset values and timing for the pulse drive block
`ifndef MPD_DEFS_SVH
`define MPD_DEFS_SVH

// Register byte offsets
`define MPD_ADDR_CMD 8'h00
`define MPD_ADDR_DATA 8'h04
`define MPD_ADDR_CONFIG 8'h08
`define MPD_ADDR_DELAY 8'h0c
`define MPD_ADDR_STATUS 8'h10
`define MPD_ADDR_POSITION 8'h14
`define MPD_ADDR_IRQ_STATUS 8'h18
`define MPD_ADDR_IRQ_CLEAR 8'h1c
`define MPD_ADDR_IRQ_ENABLE 8'h20
`define MPD_ADDR_RATE 8'h24

// Command fields
`define MPD_CMD_MOVE_MSB 2
`define MPD_CMD_DIR_BIT 3
`define MPD_MOVE_INC 3'h0
`define MPD_MOVE_ABS 3'h1
`define MPD_MOVE_SCAN 3'h2
`define MPD_MOVE_SPSCAN 3'h3
`define MPD_MOVE_ORG 3'h4
`define MPD_MOVE_STOP 3'h7

// Delay register fields
`define MPD_LIMIT_DLY_LSB 0
`define MPD_SCAN_DLY_LSB 8
`define MPD_JOG_DLY_LSB 16

// Interrupt bits
`define MPD_IRQ_DONE_BIT 0
`define MPD_IRQ_ERR_BIT 1

// Reset values and the largest accepted origin type
`define MPD_RATE_RESET 24'h0000c8
`define MPD_DELAY_RESET 24'h000000
`define MPD_ORG_TYPE_MAX 3'h5

// AXI responses
`define MPD_RESP_OKAY 2'h0
`define MPD_RESP_SLVERR 2'h2

// Timing: delay unit is one millisecond
`define MPD_CLK_PERIOD_NS 5
`define MPD_DELAY_UNIT_NS 1000000

`endif

// file: logic/mpd_pkg.sv
// Types shared by the pulse drive block
package mpd_pkg;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_HOLD = 3'b001,
    ST_RUN = 3'b010,
    ST_DELAY = 3'b011,
    ST_SERVO = 3'b100
  } mpd_state_type;

  typedef enum logic [2:0] {
    PH_SEEK = 3'b000,
    PH_BACK = 3'b001,
    PH_LEAVE = 3'b010,
    PH_JOG = 3'b011,
    PH_EXTRA = 3'b100
  } mpd_phase_type;

  typedef struct packed {
    logic pos_done;
    logic second_stop_end_flag;
    logic limit_stop_end_flag;
    logic error;
    logic drive;
    logic busy;
  } mpd_status_type;

  typedef struct packed {
    logic [2:0] org_type;
    logic servo;
  } mpd_config_type;

endpackage

// file: logic/mpd_delay_timer.sv
// Down-counting delay timer for origin seek pauses
`timescale 1ns/1ps
module mpd_delay_timer
  import mpd_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Control
  input wire logic i_load,
  input wire logic [7:0] i_value,
  input wire logic i_tick,
  // Result
  output logic o_done
);
  logic active;
  logic [7:0] count;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      active <= 1'b0;
      count <= 8'h00;
    end else if (i_load) begin
      active <= 1'b1;
      count <= i_value;
    end else if (active && count == 8'h00) begin
      active <= 1'b0;
    end else if (active && i_tick) begin
      count <= count - 8'h01;
    end
  end

  // A zero load finishes one cycle after loading
  assign o_done = active && count == 8'h00;

endmodule // mpd_delay_timer

// file: logic/mpd_drive_top.sv
// Per-axis pulse drive sequencer with busy/drive status and AXI4-Lite registers
//
// Our own choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "mpd_defs.svh"
module mpd_drive_top
  import mpd_pkg::*;
#(
  parameter int DELAY_TICK_CYCLES = `MPD_DELAY_UNIT_NS / `MPD_CLK_PERIOD_NS
) (
  // Clock and reset
  input wire logic I_CLK,
  input wire logic I_RST_N,
  // AXI4-Lite slave
  input wire logic [7:0] I_AXI_AWADDR,
  input wire logic I_AXI_AWVALID,
  output logic O_AXI_AWREADY,
  input wire logic [31:0] I_AXI_WDATA,
  input wire logic [3:0] I_AXI_WSTRB,
  input wire logic I_AXI_WVALID,
  output logic O_AXI_WREADY,
  output logic [1:0] O_AXI_BRESP,
  output logic O_AXI_BVALID,
  input wire logic I_AXI_BREADY,
  input wire logic [7:0] I_AXI_ARADDR,
  input wire logic I_AXI_ARVALID,
  output logic O_AXI_ARREADY,
  output logic [31:0] O_AXI_RDATA,
  output logic [1:0] O_AXI_RRESP,
  output logic O_AXI_RVALID,
  input wire logic I_AXI_RREADY,
  // Motor side
  input wire logic I_SERVO_POSITIONING_DONE_INPUT,
  input wire logic I_CW_LIMIT_N,
  input wire logic I_CCW_LIMIT_INPUT_N,
  input wire logic I_ORG_SENSOR,
  input wire logic I_STOP_N,
  output logic O_PULSE,
  output logic O_DIR_CW,
  // Interrupt
  output logic O_IRQ
);
  mpd_state_type state;
  mpd_phase_type phase;
  mpd_config_type cfg;
  mpd_status_type status;
  logic [2:0] move;
  logic dir_cw, pend_run;
  logic [23:0] data_reg, position, remaining, rate, delays, rate_cnt;
  logic error, lim_end, stop_end, busy_q;
  logic [1:0] irq_status, irq_enable;
  logic [31:0] tick_cnt;
  logic tick, tmr_load, tmr_done;
  logic [7:0] tmr_value;
  logic aw_full, w_full;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_fire;
  logic pos_done;

  // Limits are active-off inputs: low means the axis is at its end
  function automatic logic limit_on(input logic cw, input logic cwn, input logic ccwn);
    limit_on = cw ? !cwn : !ccwn;
  endfunction

  function automatic logic [31:0] strb_merge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] strb);
    for (int i = 0; i < 4; i++) begin
      strb_merge[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction

  assign pos_done = I_SERVO_POSITIONING_DONE_INPUT;

  // AXI write path: address and data are accepted in either order
  assign O_AXI_AWREADY = !aw_full && !O_AXI_BVALID;
  assign O_AXI_WREADY = !w_full && !O_AXI_BVALID;
  assign wr_fire = aw_full && w_full && !O_AXI_BVALID;

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      O_AXI_BVALID <= 1'b0;
      O_AXI_BRESP <= `MPD_RESP_OKAY;
    end else begin
      if (I_AXI_AWVALID && O_AXI_AWREADY) begin
        aw_full <= 1'b1;
        aw_addr <= I_AXI_AWADDR;
      end
      if (I_AXI_WVALID && O_AXI_WREADY) begin
        w_full <= 1'b1;
        w_data <= I_AXI_WDATA;
        w_strb <= I_AXI_WSTRB;
      end
      if (wr_fire) begin
        aw_full <= 1'b0;
        w_full <= 1'b0;
        O_AXI_BVALID <= 1'b1;
        if (aw_addr == `MPD_ADDR_CMD || aw_addr == `MPD_ADDR_DATA ||
            aw_addr == `MPD_ADDR_CONFIG || aw_addr == `MPD_ADDR_DELAY ||
            aw_addr == `MPD_ADDR_IRQ_CLEAR || aw_addr == `MPD_ADDR_IRQ_ENABLE ||
            aw_addr == `MPD_ADDR_RATE) begin
          O_AXI_BRESP <= `MPD_RESP_OKAY;
        end else begin
          O_AXI_BRESP <= `MPD_RESP_SLVERR;
        end
      end else if (O_AXI_BVALID && I_AXI_BREADY) begin
        O_AXI_BVALID <= 1'b0;
      end
    end
  end

  // Command decode: moves taken only while idle, stop taken in any state
  logic cmd_write, cmd_ok, zero_move, refuse, start, stop_req;
  logic [2:0] wr_move;
  logic wr_dir, new_cw;
  logic [24:0] abs_diff;
  logic [23:0] new_dist;
  assign cmd_write = wr_fire && aw_addr == `MPD_ADDR_CMD && w_strb[0];
  assign wr_move = w_data[`MPD_CMD_MOVE_MSB:0];
  assign wr_dir = w_data[`MPD_CMD_DIR_BIT];
  assign abs_diff = {data_reg[23], data_reg} - {position[23], position};
  assign new_cw = (wr_move == `MPD_MOVE_ABS) ? !abs_diff[24] :
                  (wr_move == `MPD_MOVE_ORG) ? 1'b0 : wr_dir;
  assign new_dist = (wr_move != `MPD_MOVE_ABS) ? data_reg :
                    abs_diff[24] ? 24'(-abs_diff) : abs_diff[23:0];
  assign cmd_ok = cmd_write && state == ST_IDLE && wr_move != `MPD_MOVE_STOP;
  assign zero_move = cmd_ok && new_dist == 24'h000000 &&
                     (wr_move == `MPD_MOVE_INC || wr_move == `MPD_MOVE_ABS);
  assign refuse = cmd_ok && !zero_move &&
                  (limit_on(new_cw, I_CW_LIMIT_N, I_CCW_LIMIT_INPUT_N) ||
                   (wr_move == `MPD_MOVE_ORG && cfg.org_type > `MPD_ORG_TYPE_MAX));
  assign start = cmd_ok && !zero_move && !refuse;
  assign stop_req = (cmd_write && wr_move == `MPD_MOVE_STOP) || !I_STOP_N;

  // Running conditions
  logic drive, counted, lim_now, cond_met, step, count_end, ev_second, ev_limit, seek_lim;
  assign drive = state == ST_RUN || state == ST_HOLD;
  assign counted = move == `MPD_MOVE_INC || move == `MPD_MOVE_ABS ||
                   (move == `MPD_MOVE_ORG && phase == PH_EXTRA);
  assign lim_now = limit_on(dir_cw, I_CW_LIMIT_N, I_CCW_LIMIT_INPUT_N);
  assign seek_lim = move == `MPD_MOVE_ORG && phase == PH_SEEK && !dir_cw;
  always_comb begin
    cond_met = 1'b0;
    if (move == `MPD_MOVE_ORG) begin
      case (phase)
        PH_SEEK, PH_BACK, PH_JOG: cond_met = I_ORG_SENSOR;
        PH_LEAVE: cond_met = !I_ORG_SENSOR;
        default: cond_met = 1'b0;
      endcase
    end
  end
  assign ev_second = drive && stop_req;
  assign ev_limit = state == ST_RUN && !stop_req && lim_now && !seek_lim;
  assign step = state == ST_RUN && rate_cnt == 24'h000000 && !stop_req && !lim_now &&
                !cond_met;
  assign count_end = step && counted && remaining == 24'h000001;

  // Origin stage plan: next phase, final or not, and the pause before it
  mpd_phase_type org_next;
  logic org_final, org_cw;
  logic [7:0] org_delay;
  always_comb begin
    org_next = PH_LEAVE;
    org_final = 1'b0;
    org_cw = 1'b1;
    org_delay = delays[`MPD_SCAN_DLY_LSB +: 8];
    if (lim_now && seek_lim) begin
      org_next = PH_BACK;
      org_delay = delays[`MPD_LIMIT_DLY_LSB +: 8];
    end else begin
      case (phase)
        PH_SEEK, PH_BACK: org_final = cfg.org_type < 3'h2;
        PH_LEAVE: begin
          org_final = !(cfg.org_type == 3'h3 || cfg.org_type == 3'h5);
          org_next = PH_JOG;
          org_cw = 1'b0;
          org_delay = delays[`MPD_JOG_DLY_LSB +: 8];
        end
        PH_JOG: begin
          org_next = PH_EXTRA;
          org_cw = 1'b0;
          org_delay = 8'h00;
        end
        default: org_final = 1'b1;
      endcase
    end
  end

  logic org_stage;
  assign org_stage = state == ST_RUN && !stop_req && move == `MPD_MOVE_ORG &&
                     ((lim_now && seek_lim) || (!lim_now && cond_met)) && !org_final;
  assign tmr_load = org_stage;
  assign tmr_value = org_delay;

  // Sequencer
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      state <= ST_IDLE;
      phase <= PH_SEEK;
      move <= `MPD_MOVE_INC;
      dir_cw <= 1'b1;
      remaining <= 24'h000000;
      pend_run <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (start) begin
            move <= wr_move;
            dir_cw <= new_cw;
            remaining <= new_dist;
            phase <= PH_SEEK;
            pend_run <= 1'b0;
            state <= (cfg.servo && pos_done) ? ST_HOLD : ST_RUN;
          end
        end
        ST_HOLD: begin
          if (stop_req) begin
            state <= ST_IDLE;
          end else if (!pos_done) begin
            state <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (stop_req || ev_limit) begin
            state <= cfg.servo ? ST_SERVO : ST_IDLE;
          end else if (org_stage) begin
            phase <= org_next;
            dir_cw <= org_cw;
            remaining <= 24'h000001;
            pend_run <= 1'b1;
            state <= ST_DELAY;
          end else if ((cond_met && move == `MPD_MOVE_ORG) || count_end) begin
            state <= cfg.servo ? ST_SERVO : ST_IDLE;
          end else if (step && counted) begin
            remaining <= remaining - 24'h000001;
          end
        end
        ST_DELAY: begin
          if (stop_req) begin
            pend_run <= 1'b0;
            state <= ST_IDLE;
          end else if (tmr_done) begin
            state <= cfg.servo ? ST_SERVO : ST_RUN;
          end
        end
        default: begin
          if (stop_req && pend_run) begin
            pend_run <= 1'b0;
          end else if (!pos_done) begin
            state <= pend_run ? ST_RUN : ST_IDLE;
            pend_run <= 1'b0;
          end
        end
      endcase
    end
  end

  // Pulse timing and position
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      rate_cnt <= 24'h000000;
      position <= 24'h000000;
      O_PULSE <= 1'b0;
      O_DIR_CW <= 1'b1;
    end else begin
      O_PULSE <= step;
      O_DIR_CW <= dir_cw;
      if (state != ST_RUN || step) begin
        rate_cnt <= (rate == 24'h000000) ? 24'h000000 : rate - 24'h000001;
      end else if (rate_cnt != 24'h000000) begin
        rate_cnt <= rate_cnt - 24'h000001;
      end
      if (step) begin
        position <= dir_cw ? position + 24'h000001 : position - 24'h000001;
      end
    end
  end

  // Delay tick divider, then the pause timer
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      tick_cnt <= 32'h0000_0000;
    end else if (tick_cnt >= 32'(DELAY_TICK_CYCLES - 1)) begin
      tick_cnt <= 32'h0000_0000;
    end else begin
      tick_cnt <= tick_cnt + 32'h0000_0001;
    end
  end
  assign tick = tick_cnt == 32'h0000_0000;

  mpd_delay_timer u_timer (
    .i_clk(I_CLK),
    .i_rst_n(I_RST_N),
    .i_load(tmr_load),
    .i_value(tmr_value),
    .i_tick(tick),
    .o_done(tmr_done)
  );

  // Cause flags: cleared when the next move starts, the end flags also by a refusal; an event in that cycle wins
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      error <= 1'b0;
      lim_end <= 1'b0;
      stop_end <= 1'b0;
    end else begin
      error <= refuse || (error && !start);
      lim_end <= ev_limit || (lim_end && !start && !refuse);
      stop_end <= ev_second || (stop_end && !start && !refuse);
    end
  end

  // Software registers
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      data_reg <= 24'h000000;
      cfg <= '0;
      delays <= `MPD_DELAY_RESET;
      rate <= `MPD_RATE_RESET;
      irq_enable <= 2'h0;
    end else if (wr_fire) begin
      if (aw_addr == `MPD_ADDR_DATA && state == ST_IDLE) begin
        data_reg <= 24'(strb_merge({8'h00, data_reg}, w_data, w_strb));
      end else if (aw_addr == `MPD_ADDR_CONFIG && w_strb[0] && state == ST_IDLE) begin
        cfg <= w_data[3:0];
      end else if (aw_addr == `MPD_ADDR_DELAY) begin
        delays <= 24'(strb_merge({8'h00, delays}, w_data, w_strb));
      end else if (aw_addr == `MPD_ADDR_RATE) begin
        rate <= 24'(strb_merge({8'h00, rate}, w_data, w_strb));
      end else if (aw_addr == `MPD_ADDR_IRQ_ENABLE && w_strb[0]) begin
        irq_enable <= w_data[1:0];
      end
    end
  end

  // Interrupt status: set wins over a clear in the same cycle
  logic [1:0] irq_set, irq_clr;
  assign irq_set[`MPD_IRQ_DONE_BIT] = busy_q && state == ST_IDLE;
  assign irq_set[`MPD_IRQ_ERR_BIT] = refuse || ev_limit || ev_second;
  assign irq_clr = (wr_fire && aw_addr == `MPD_ADDR_IRQ_CLEAR && w_strb[0]) ? w_data[1:0] : 2'h0;
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      irq_status <= 2'h0;
      busy_q <= 1'b0;
    end else begin
      irq_status <= irq_set | (irq_status & ~irq_clr);
      busy_q <= state != ST_IDLE;
    end
  end
  assign O_IRQ = |(irq_status & irq_enable);

  // Status image
  always_comb begin
    status.busy = state != ST_IDLE;
    status.drive = drive;
    status.error = error;
    status.limit_stop_end_flag = lim_end;
    status.second_stop_end_flag = stop_end;
    status.pos_done = pos_done;
  end

  // AXI read path
  assign O_AXI_ARREADY = !O_AXI_RVALID;
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_AXI_RVALID <= 1'b0;
      O_AXI_RDATA <= 32'h0000_0000;
      O_AXI_RRESP <= `MPD_RESP_OKAY;
    end else if (I_AXI_ARVALID && O_AXI_ARREADY) begin
      O_AXI_RVALID <= 1'b1;
      O_AXI_RRESP <= `MPD_RESP_OKAY;
      if (I_AXI_ARADDR == `MPD_ADDR_DATA) begin
        O_AXI_RDATA <= {8'h00, data_reg};
      end else if (I_AXI_ARADDR == `MPD_ADDR_CONFIG) begin
        O_AXI_RDATA <= {28'h0000000, cfg};
      end else if (I_AXI_ARADDR == `MPD_ADDR_DELAY) begin
        O_AXI_RDATA <= {8'h00, delays};
      end else if (I_AXI_ARADDR == `MPD_ADDR_STATUS) begin
        O_AXI_RDATA <= {26'h0000000, status};
      end else if (I_AXI_ARADDR == `MPD_ADDR_POSITION) begin
        O_AXI_RDATA <= {{8{position[23]}}, position};
      end else if (I_AXI_ARADDR == `MPD_ADDR_IRQ_STATUS) begin
        O_AXI_RDATA <= {30'h00000000, irq_status};
      end else if (I_AXI_ARADDR == `MPD_ADDR_IRQ_ENABLE) begin
        O_AXI_RDATA <= {30'h00000000, irq_enable};
      end else if (I_AXI_ARADDR == `MPD_ADDR_RATE) begin
        O_AXI_RDATA <= {8'h00, rate};
      end else begin
        O_AXI_RDATA <= 32'h0000_0000;
        O_AXI_RRESP <= `MPD_RESP_SLVERR;
      end
    end else if (O_AXI_RVALID && I_AXI_RREADY) begin
      O_AXI_RVALID <= 1'b0;
    end
  end

  // Checks
  busy_set_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    start |=> status.busy ##0 status.drive) else $error("busy not set after start");
  zero_move_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    zero_move |=> !status.busy && !status.drive [*2]) else $error("zero move went busy");
  refuse_flag_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    refuse |=> error && !status.busy) else $error("refusal not flagged");
  limit_flag_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    ev_limit |=> lim_end && !status.drive) else $error("limit stop not flagged");
  done_hold_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    state == ST_HOLD && pos_done && !stop_req |=> status.drive && status.busy && !O_PULSE)
    else $error("pulse while done input high");
  servo_busy_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    state == ST_SERVO && pos_done |=> status.busy) else $error("busy dropped early");
  scan_run_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    state == ST_RUN && move == `MPD_MOVE_SCAN && !stop_req && !lim_now |=> status.drive)
    else $error("scan ended without stop");
  count_end_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    count_end && !cfg.servo |=> !status.busy ##1 !O_PULSE) else $error("index overran");
  org_wait_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    state == ST_SERVO && pend_run && pos_done && !stop_req |=> state == ST_SERVO)
    else $error("seek went on without done input");
  extra_one_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    state == ST_RUN && phase == PH_EXTRA && step |=> state != ST_RUN)
    else $error("more than one extra pulse");
  delay_apply_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    org_stage && org_delay != 8'h00 |=> state == ST_DELAY ##1
    (state == ST_DELAY || $past(stop_req)))
    else $error("origin delay skipped");
  cov_index_c: cover property (@(posedge I_CLK) disable iff (!I_RST_N) count_end);
  cov_servo_c: cover property (@(posedge I_CLK) disable iff (!I_RST_N)
    state == ST_HOLD ##[1:20] state == ST_RUN);
  cov_org_c: cover property (@(posedge I_CLK) disable iff (!I_RST_N)
    state == ST_RUN && phase == PH_EXTRA && step);

endmodule // mpd_drive_top

// file: verif/mpd_axis_model.sv
// Servo driver and origin sensor model for one axis
`timescale 1ns/1ps
module mpd_axis_model #(
  parameter int SETTLE = 6,
  parameter int ORG_LO = -10,
  parameter int ORG_HI = -5
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Drive side
  input wire logic i_pulse,
  input wire logic i_dir_cw,
  input wire logic i_hold,
  // Feedback
  output logic o_done,
  output logic o_org,
  output int o_pos
);
  int settle;
  // Settling restarts on every step, so the done input covers a whole run
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pos <= 0;
      settle <= 0;
    end else if (i_pulse) begin
      o_pos <= i_dir_cw ? o_pos + 1 : o_pos - 1;
      settle <= SETTLE;
    end else if (settle != 0) begin
      settle <= settle - 1;
    end
  end
  assign o_done = i_hold || (settle != 0);
  assign o_org = (o_pos >= ORG_LO) && (o_pos <= ORG_HI);
endmodule // mpd_axis_model

// file: verif/motor_pulse_drive_status_bench.sv
// Self-checking bench for the pulse drive sequencer
`timescale 1ns/1ps
`include "mpd_defs.svh"
module motor_pulse_drive_status_bench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic cw_lim_n = 1'b1;
  logic hold = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, done_in, org, pulse, dir_cw, irq;
  logic [1:0] bresp, bresp_q, rresp, rresp_q;
  logic [31:0] rdata, rd_val;
  int pos;
  int npulse = 0;
  int error_cnt = 0;
  int num_checks = 0;
  int exp_pos[6] = '{-5, -5, -4, -6, -4, -6};

  initial begin
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) if (pulse === 1'b1) npulse <= npulse + 1;

  mpd_drive_top #(.DELAY_TICK_CYCLES(4)) mpd_drive_top_i (
    .I_CLK(clk), .I_RST_N(rst_n),
    .I_AXI_AWADDR(awaddr), .I_AXI_AWVALID(awvalid), .O_AXI_AWREADY(awready),
    .I_AXI_WDATA(wdata), .I_AXI_WSTRB(4'hf), .I_AXI_WVALID(wvalid), .O_AXI_WREADY(wready),
    .O_AXI_BRESP(bresp), .O_AXI_BVALID(bvalid), .I_AXI_BREADY(bready),
    .I_AXI_ARADDR(araddr), .I_AXI_ARVALID(arvalid), .O_AXI_ARREADY(arready),
    .O_AXI_RDATA(rdata), .O_AXI_RRESP(rresp), .O_AXI_RVALID(rvalid), .I_AXI_RREADY(rready),
    .I_SERVO_POSITIONING_DONE_INPUT(done_in), .I_CW_LIMIT_N(cw_lim_n),
    .I_CCW_LIMIT_INPUT_N(1'b1), .I_ORG_SENSOR(org), .I_STOP_N(1'b1),
    .O_PULSE(pulse), .O_DIR_CW(dir_cw), .O_IRQ(irq));

  mpd_axis_model mpd_axis_model_i (.i_clk(clk), .i_rst_n(rst_n), .i_pulse(pulse),
    .i_dir_cw(dir_cw), .i_hold(hold), .o_done(done_in), .o_org(org), .o_pos(pos));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Ready is combinational on registered state, so its value at the falling edge is what
  // the next rising edge samples
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_t, w_t, b_t;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge clk);
      aw_t = awvalid && (awready === 1'b1);
      w_t = wvalid && (wready === 1'b1);
      b_t = (bvalid === 1'b1);
      bresp_q = bresp;
      @(posedge clk);
      if (aw_t) awvalid <= 1'b0;
      if (w_t) wvalid <= 1'b0;
      if (b_t) bready <= 1'b0;
    end while (!b_t);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    logic a_t, r_t;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge clk);
      a_t = arvalid && (arready === 1'b1);
      r_t = (rvalid === 1'b1);
      d = rdata;
      rresp_q = rresp;
      @(posedge clk);
      if (a_t) arvalid <= 1'b0;
      if (r_t) rready <= 1'b0;
    end while (!r_t);
  endtask

  task automatic wait_idle();
    int n = 0;
    do begin
      rd(`MPD_ADDR_STATUS, rd_val);
      n++;
    end while (rd_val[0] !== 1'b0 && n < 2000);
    chk({31'h0, rd_val[0]}, 32'h0);
  endtask

  task automatic t_zero();
    int p0 = npulse;
    wr(`MPD_ADDR_DATA, 32'h0);
    wr(`MPD_ADDR_CMD, 32'h0);
    repeat (10) @(posedge clk);
    rd(`MPD_ADDR_STATUS, rd_val);
    chk(rd_val & 32'h3, 32'h0);
    chk(32'(npulse - p0), 32'h0);
  endtask

  task automatic t_index();
    int p0 = npulse;
    wr(`MPD_ADDR_RATE, 32'h4);
    wr(`MPD_ADDR_IRQ_ENABLE, 32'h1);
    wr(`MPD_ADDR_DATA, 32'h5);
    wr(`MPD_ADDR_CMD, 32'h8);
    rd(`MPD_ADDR_STATUS, rd_val);
    chk(rd_val & 32'h3, 32'h3);
    wait_idle();
    chk(32'(npulse - p0), 32'h5);
    chk(32'(pos), 32'h5);
    chk({31'h0, irq}, 32'h1);
    wr(`MPD_ADDR_IRQ_CLEAR, 32'h3);
    chk({31'h0, irq}, 32'h0);
  endtask

  task automatic t_scan_stop();
    wr(`MPD_ADDR_CMD, 32'h2);
    repeat (100) @(posedge clk);
    rd(`MPD_ADDR_STATUS, rd_val);
    chk(rd_val & 32'h3, 32'h3);
    wr(`MPD_ADDR_CMD, 32'h7);
    wait_idle();
    chk(rd_val & 32'h18, 32'h10);
  endtask

  task automatic t_limit();
    @(posedge clk);
    cw_lim_n <= 1'b0;
    wr(`MPD_ADDR_CMD, 32'h8);
    rd(`MPD_ADDR_STATUS, rd_val);
    chk(rd_val & 32'h7, 32'h4);
    cw_lim_n <= 1'b1;
  endtask

  task automatic t_servo();
    int p0 = npulse;
    wr(`MPD_ADDR_CONFIG, 32'h1);
    hold <= 1'b1;
    wr(`MPD_ADDR_DATA, 32'h2);
    wr(`MPD_ADDR_CMD, 32'h8);
    repeat (40) @(posedge clk);
    rd(`MPD_ADDR_STATUS, rd_val);
    chk(rd_val & 32'h3, 32'h3);
    chk(32'(npulse - p0), 32'h0);
    hold <= 1'b0;
    for (int n = 0; n < 200 && npulse - p0 < 2; n++) @(posedge clk);
    hold <= 1'b1;
    repeat (20) @(posedge clk);
    rd(`MPD_ADDR_STATUS, rd_val);
    chk(rd_val & 32'h3, 32'h1);
    hold <= 1'b0;
    wait_idle();
  endtask

  task automatic t_org();
    wr(`MPD_ADDR_DELAY, 32'h010101);
    for (int t = 0; t < 6; t++) begin
      wr(`MPD_ADDR_DATA, 32'h0);
      wr(`MPD_ADDR_CMD, 32'h1);
      wait_idle();
      chk(32'(pos), 32'h0);
      wr(`MPD_ADDR_CONFIG, {28'h0, 3'(t), 1'b1});
      wr(`MPD_ADDR_CMD, 32'h4);
      wait_idle();
      chk(32'(pos), 32'(exp_pos[t]));
    end
    // Origin type six is outside the supported set and must be refused
    wr(`MPD_ADDR_CONFIG, 32'hc);
    wr(`MPD_ADDR_CMD, 32'h4);
    rd(`MPD_ADDR_STATUS, rd_val);
    chk(rd_val & 32'h7, 32'h4);
  endtask

  task automatic results();
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    #150000;
    error_cnt++;
    results();
  end

  initial begin
    repeat (20) @(posedge clk);
    chk(32'(npulse), 32'h0);
    rst_n <= 1'b1;
    rd(`MPD_ADDR_STATUS, rd_val);
    chk(rd_val & 32'h3f, 32'h0);
    rd(8'hfc, rd_val);
    chk({30'h0, rresp_q}, {30'h0, `MPD_RESP_SLVERR});
    // Status is read-only, so a write to it is answered with an error
    wr(`MPD_ADDR_STATUS, 32'h0);
    chk({30'h0, bresp_q}, {30'h0, `MPD_RESP_SLVERR});
    t_zero();
    t_index();
    t_scan_stop();
    t_limit();
    t_servo();
    t_org();
    results();
  end
endmodule // motor_pulse_drive_status_bench
